// ===== core/sdmb_pkg.sv
// constants and types for the quad-bank sdram command core
package sdmb_pkg;
  localparam int BANKS         = 4;
  localparam int ROW_W         = 11;
  localparam int COL_W         = 8;
  localparam int DATA_W        = 32;
  localparam int BANK_W        = 2;
  localparam int ADDR_W        = 12;
  localparam int PCHG_ALL_POS  = 10;
  localparam int CLK_MHZ       = 20;
  localparam int FIFO_DEPTH    = 32;
  // timing figures in ns and derived cycle counts
  localparam int PRECHARGE_PERIOD_NS   = 20;
  localparam int WRITE_RECOVERY_NS     = 14;
  localparam int ACT_TO_ACCESS_NS      = 20;
  localparam int SELF_REF_EXIT_NS      = 70;
  localparam int PRECHARGE_CYC = (PRECHARGE_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_REC_CYC    = (WRITE_RECOVERY_NS * CLK_MHZ + 999) / 1000;
  localparam int ACT_CYC       = (ACT_TO_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SR_EXIT_CYC   = (SELF_REF_EXIT_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_LAT_RST   = 2;
  localparam int BURST_LEN_RST = 8;
  localparam int CNT_W         = 4;
  typedef enum logic [3:0] {
    SDMB_CMD_NOP, SDMB_CMD_ACT, SDMB_CMD_RD, SDMB_CMD_WR, SDMB_CMD_PRE,
    SDMB_CMD_BST, SDMB_CMD_REF, SDMB_CMD_MRS
  } sdmb_cmd_e;
  typedef enum logic [2:0] {
    SDMB_IDLE, SDMB_ACTIVATING, SDMB_ACTIVE, SDMB_PRECHARGING, SDMB_WR_RECOVER
  } sdmb_bank_e;
endpackage

// ===== core/sdmb_fifo.sv
// parameterised valid/ready fifo holding read data
`timescale 1ns/1ps
module sdmb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;
  // full at exactly DEPTH words; the extra count bit tells full from empty
  assign in_ready  = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      if (pop)  rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      count_reg <= (AW+1)'(count_reg + push - pop);
    end
  end
endmodule // sdmb_fifo

// ===== core/sdmb_core.sv
// quad-bank sdram command decode, bank tracking and burst engine
`timescale 1ns/1ps
module sdmb_core
  import sdmb_pkg::*;
#(
  parameter int SR_EXIT = SR_EXIT_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      clock_enable,
  input  wire logic                      chip_select_n,
  input  wire logic                      row_strobe_n,
  input  wire logic                      column_strobe_n,
  input  wire logic                      write_enable_n,
  input  wire logic                      bank_select_lo,
  input  wire logic                      bank_select_hi,
  input  wire logic [sdmb_pkg::ADDR_W-1:0] address,
  input  wire logic [sdmb_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                byte_mask,
  input  wire logic                      self_refresh_exit,
  output logic      [sdmb_pkg::DATA_W-1:0] rdata,
  output logic                           rdata_valid,
  input  wire logic                      rdata_ready,
  output logic      [sdmb_pkg::BANKS-1:0]  bank_idle
);
  import sdmb_pkg::*;
  localparam int MEM_W = BANK_W + ROW_W + COL_W;
  localparam int MEM_N = 64;
  // clock enable history, decoded pins, mode and bank state
  logic              cke_reg;
  sdmb_cmd_e         cmd;
  logic [BANK_W-1:0] bank;
  logic [1:0]        cas_lat_reg;
  logic [3:0]        blen_reg;
  logic [CNT_W-1:0]  sr_cnt_reg;
  logic              cmd_ok;
  sdmb_bank_e        bst_reg [BANKS];
  logic [CNT_W-1:0]  tmr_reg [BANKS];
  logic [ROW_W-1:0]  row_reg [BANKS];
  logic [BANKS-1:0]  ap_pend_reg;
  // burst engine
  logic              bur_rd_reg;
  logic              bur_wr_reg;
  logic [BANK_W-1:0] bur_bank_reg;
  logic              bur_ap_reg;
  logic [COL_W-1:0]  bur_col_reg;
  logic [3:0]        bur_left_reg;
  logic [DATA_W-1:0] mem_reg [MEM_N];
  logic [DATA_W-1:0] rd_pipe_reg [3];
  logic [2:0]        rd_vld_pipe_reg;
  logic              fifo_ready;
  logic [5:0]        rd_idx;
  logic [5:0]        wr_idx;
  // column stepping inside the burst block
  logic [COL_W-1:0]  col_mask;
  logic [COL_W-1:0]  col_start_nxt;
  logic [COL_W-1:0]  col_run_nxt;

  assign bank = {bank_select_hi, bank_select_lo};

  // clock enable history and self refresh exit wait
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cke_reg      <= 1'b0;
      sr_cnt_reg   <= '0;
    end else begin
      cke_reg      <= clock_enable;
      if (self_refresh_exit)
        sr_cnt_reg <= CNT_W'(SR_EXIT);
      else if (sr_cnt_reg != '0)
        sr_cnt_reg <= CNT_W'(sr_cnt_reg - 1'b1);
    end
  end
  // previous edge comes from cke_reg, current edge straight from the pin
  assign cmd_ok = cke_reg && clock_enable && (sr_cnt_reg == '0);

  // command decode from strobes
  always_comb begin
    cmd = SDMB_CMD_NOP;
    if (!chip_select_n && cmd_ok) begin
      unique case ({row_strobe_n, column_strobe_n, write_enable_n})
        3'b011:  cmd = SDMB_CMD_ACT;
        3'b101:  cmd = SDMB_CMD_RD;
        3'b100:  cmd = SDMB_CMD_WR;
        3'b010:  cmd = SDMB_CMD_PRE;
        3'b110:  cmd = SDMB_CMD_BST;
        3'b001:  cmd = SDMB_CMD_REF;
        3'b000:  cmd = SDMB_CMD_MRS;
        default: cmd = SDMB_CMD_NOP;
      endcase
    end
  end

  // mode load keeps latency and burst length; controller ensures idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cas_lat_reg <= 2'(CAS_LAT_RST);
      blen_reg    <= 4'(BURST_LEN_RST);
    end else if (cmd == SDMB_CMD_MRS) begin
      cas_lat_reg <= (address[6:4] == 3'h3) ? 2'h3 : 2'h2;
      unique case (address[2:0])
        3'h0:    blen_reg <= 4'h1;
        3'h1:    blen_reg <= 4'h2;
        3'h2:    blen_reg <= 4'h4;
        default: blen_reg <= 4'h8;
      endcase
    end
  end

  // per-bank state; each bank reacts to its own commands, precharge all, and reads/writes that cut its auto precharge burst
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      logic hit;
      logic all_pre;
      logic interrupted;
      assign hit     = (bank == BANK_W'(b));
      assign all_pre = address[PCHG_ALL_POS];
      // another bank's read/write ends this bank's auto precharge burst
      assign interrupted = (bur_rd_reg || bur_wr_reg) && bur_ap_reg
                        && (bur_bank_reg == BANK_W'(b)) && !hit
                        && (cmd == SDMB_CMD_RD || cmd == SDMB_CMD_WR);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          bst_reg[b]     <= SDMB_IDLE;
          tmr_reg[b]     <= '0;
          row_reg[b]     <= '0;
          ap_pend_reg[b] <= 1'b0;
        end else begin
          if (tmr_reg[b] != '0)
            tmr_reg[b] <= CNT_W'(tmr_reg[b] - 1'b1);
          unique case (bst_reg[b])
            SDMB_ACTIVATING:
              if (tmr_reg[b] <= CNT_W'(1)) bst_reg[b] <= SDMB_ACTIVE;
            SDMB_PRECHARGING:
              if (tmr_reg[b] <= CNT_W'(1)) bst_reg[b] <= SDMB_IDLE;
            SDMB_WR_RECOVER:
              if (tmr_reg[b] <= CNT_W'(1)) begin
                bst_reg[b] <= SDMB_PRECHARGING;
                tmr_reg[b] <= CNT_W'(PRECHARGE_CYC);
              end
            default: ;
          endcase
          if (interrupted && bur_rd_reg) begin
            bst_reg[b]     <= SDMB_PRECHARGING;
            tmr_reg[b]     <= CNT_W'(PRECHARGE_CYC);
            ap_pend_reg[b] <= 1'b0;
          end else if (interrupted && bur_wr_reg) begin
            bst_reg[b]     <= SDMB_WR_RECOVER;
            tmr_reg[b]     <= CNT_W'(WR_REC_CYC);
            ap_pend_reg[b] <= 1'b0;
          end else if (ap_pend_reg[b] && bur_left_reg == 4'h1
                       && bur_bank_reg == BANK_W'(b)) begin
            bst_reg[b]     <= SDMB_PRECHARGING; // end of own auto precharge burst
            tmr_reg[b]     <= CNT_W'(PRECHARGE_CYC);
            ap_pend_reg[b] <= 1'b0;
          end
          if (cmd == SDMB_CMD_ACT && hit && bst_reg[b] == SDMB_IDLE) begin
            bst_reg[b] <= SDMB_ACTIVATING;
            tmr_reg[b] <= CNT_W'(ACT_CYC);
            row_reg[b] <= address[ROW_W-1:0];
          end
          if (cmd == SDMB_CMD_PRE && (hit || all_pre)
              && bst_reg[b] == SDMB_ACTIVE) begin
            bst_reg[b] <= SDMB_PRECHARGING;
            tmr_reg[b] <= CNT_W'(PRECHARGE_CYC);
          end
          if ((cmd == SDMB_CMD_RD || cmd == SDMB_CMD_WR) && hit
              && bst_reg[b] == SDMB_ACTIVE)
            ap_pend_reg[b] <= address[PCHG_ALL_POS];
        end
      end
      assign bank_idle[b] = (bst_reg[b] == SDMB_IDLE);
    end
  endgenerate

  // burst wraps inside its block of burst length columns, never crossing it
  assign col_mask      = COL_W'(blen_reg - 1'b1);
  assign col_start_nxt = (address[COL_W-1:0] & ~col_mask)
                       | (COL_W'(address[COL_W-1:0] + 1'b1) & col_mask);
  assign col_run_nxt   = (bur_col_reg & ~col_mask)
                       | (COL_W'(bur_col_reg + 1'b1) & col_mask);

  // burst engine: newest read/write replaces the running burst
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bur_rd_reg   <= 1'b0;
      bur_wr_reg   <= 1'b0;
      bur_bank_reg <= '0;
      bur_ap_reg   <= 1'b0;
      bur_col_reg  <= '0;
      bur_left_reg <= '0;
    end else if ((cmd == SDMB_CMD_RD || cmd == SDMB_CMD_WR)
                 && bst_reg[bank] == SDMB_ACTIVE) begin
      bur_rd_reg   <= (cmd == SDMB_CMD_RD);
      bur_wr_reg   <= (cmd == SDMB_CMD_WR);
      bur_bank_reg <= bank;
      bur_ap_reg   <= address[PCHG_ALL_POS];
      bur_col_reg  <= col_start_nxt;
      bur_left_reg <= 4'(blen_reg - 1'b1);
    end else if (cmd == SDMB_CMD_BST || bur_left_reg <= 4'h1) begin
      bur_rd_reg   <= 1'b0; // terminate acts on current burst only
      bur_wr_reg   <= 1'b0;
      bur_left_reg <= '0;
    end else begin
      // precharge to another bank lands here: burst runs on
      bur_col_reg  <= col_run_nxt;
      bur_left_reg <= 4'(bur_left_reg - 1'b1);
    end
  end

  // small storage window: low column bits and bank select the word
  assign wr_idx = (cmd == SDMB_CMD_WR) ? {bank, address[3:0]}
                                       : {bur_bank_reg, bur_col_reg[3:0]};
  assign rd_idx = (cmd == SDMB_CMD_RD) ? {bank, address[3:0]}
                                       : {bur_bank_reg, bur_col_reg[3:0]};
  always_ff @(posedge clk) begin
    if ((cmd == SDMB_CMD_WR && bst_reg[bank] == SDMB_ACTIVE)
        || (bur_wr_reg && bur_left_reg != '0 && cmd != SDMB_CMD_RD
            && cmd != SDMB_CMD_WR && cmd != SDMB_CMD_BST)) begin
      if (byte_mask == 4'h0) mem_reg[wr_idx] <= wdata;
    end
  end

  // read pipeline: depth follows cas latency, new read overtakes old
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_vld_pipe_reg <= '0;
      for (int i = 0; i < 3; i++) rd_pipe_reg[i] <= '0;
    end else begin
      rd_pipe_reg[0]     <= mem_reg[rd_idx];
      rd_vld_pipe_reg[0] <= (cmd == SDMB_CMD_RD && bst_reg[bank] == SDMB_ACTIVE)
                         || (bur_rd_reg && bur_left_reg != '0
                             && cmd != SDMB_CMD_WR && cmd != SDMB_CMD_BST);
      rd_pipe_reg[1]     <= rd_pipe_reg[0];
      rd_vld_pipe_reg[1] <= rd_vld_pipe_reg[0];
      rd_pipe_reg[2]     <= rd_pipe_reg[1];
      rd_vld_pipe_reg[2] <= rd_vld_pipe_reg[1];
    end
  end

  // output buffer; full fifo drops words since the dram cannot stall
  sdmb_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  ((cas_lat_reg == 2'h3) ? rd_vld_pipe_reg[2] : rd_vld_pipe_reg[1]),
    .in_ready  (fifo_ready),
    .in_data   ((cas_lat_reg == 2'h3) ? rd_pipe_reg[2] : rd_pipe_reg[1]),
    .out_valid (rdata_valid),
    .out_ready (rdata_ready),
    .out_data  (rdata)
  );
endmodule // sdmb_core

// ===== verification/sdmb_core_chk.sv
// port checker for the sdram command core
`timescale 1ns/1ps
module sdmb_core_chk
  import sdmb_pkg::*;
#(parameter int SR_EXIT = SR_EXIT_CYC) (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        clock_enable,
  input wire logic                        chip_select_n,
  input wire logic                        row_strobe_n,
  input wire logic                        column_strobe_n,
  input wire logic                        write_enable_n,
  input wire logic                        bank_select_lo,
  input wire logic                        bank_select_hi,
  input wire logic [sdmb_pkg::ADDR_W-1:0] address,
  input wire logic [sdmb_pkg::DATA_W-1:0] rdata,
  input wire logic                        rdata_valid,
  input wire logic                        rdata_ready,
  input wire logic [sdmb_pkg::BANKS-1:0]  bank_idle
);
  logic [1:0] age_reg;
  logic       cke_reg;
  logic [1:0] pb_reg;
  wire  [1:0] bk = {bank_select_hi, bank_select_lo};
  wire  [2:0] c = {row_strobe_n, column_strobe_n, write_enable_n};
  // conservative settle time so early decode slack never fires
  wire ok  = !chip_select_n && clock_enable && cke_reg && age_reg == 2'h3;
  wire act = ok && c == 3'h3;
  wire rd  = ok && c == 3'h5;
  wire wr  = ok && c == 3'h4;
  wire pre = ok && c == 3'h2;
  wire ap  = address[PCHG_ALL_POS];
  // edges since reset, clock enable history, last precharged bank
  always_ff @(posedge clk) begin
    if (!rst_n) age_reg <= 2'h0;
    else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
  end
  always_ff @(posedge clk) cke_reg <= clock_enable;
  always_ff @(posedge clk) if (pre) pb_reg <= bk;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  inhibit_keeps_idle_a: assert property (chip_select_n && &bank_idle |=> &bank_idle)
    else $error("inhibit changed idle banks");
  act_opens_bank_a: assert property (act && bank_idle[bk] |=> !bank_idle[$past(bk)])
    else $error("active left bank idle");
  cke_gates_cmd_a: assert property (!cke_reg && age_reg == 2'h3 && !chip_select_n
    && c == 3'h3 && bank_idle[bk] |=> bank_idle[$past(bk)])
    else $error("command taken with clock enable low");
  pre_all_idle_a: assert property (pre && ap |-> ##[1:3] &bank_idle)
    else $error("precharge all left a bank open");
  pre_one_idle_a: assert property (pre && !ap |-> ##[1:3] bank_idle[pb_reg])
    else $error("precharged bank not idle");
  read_answer_a: assert property (rd && !bank_idle[bk] && !rdata_valid |-> ##[2:5] rdata_valid)
    else $error("read data late");
  rdata_holds_a: assert property (rdata_valid && !rdata_ready |=> rdata_valid && $stable(rdata))
    else $error("read word dropped under stall");
  rd_ap_close_a: assert property (rd && ap && bk == 2'h0 ##2 rd && bk == 2'h1
    |-> ##[1:5] bank_idle[0])
    else $error("read auto precharge not started");
  wr_ap_close_a: assert property (wr && ap && bk == 2'h0 ##2 wr && bk == 2'h1
    |=> !bank_idle[0] ##[1:5] bank_idle[0])
    else $error("write auto precharge timing wrong");
  cover property (rd && ap);
  cover property (wr && ap);
  cover property (rdata_valid && !rdata_ready);
endmodule // sdmb_core_chk

bind sdmb_core sdmb_core_chk #(.SR_EXIT(SR_EXIT)) u_chk (
  .clk(clk), .rst_n(rst_n), .clock_enable(clock_enable), .chip_select_n(chip_select_n),
  .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
  .write_enable_n(write_enable_n), .bank_select_lo(bank_select_lo),
  .bank_select_hi(bank_select_hi), .address(address), .rdata(rdata),
  .rdata_valid(rdata_valid), .rdata_ready(rdata_ready), .bank_idle(bank_idle)
);

// ===== verification/sdmb_ctl_model.sv
// controller model issuing commands to the sdram core
`timescale 1ns/1ps
module sdmb_ctl_model #(
  parameter int POWER_UP_CYC = 2000,
  parameter int GAP_CYC      = 8
) (
  input  wire logic   clk,
  output logic        clock_enable,
  output logic        chip_select_n,
  output logic        row_strobe_n,
  output logic        column_strobe_n,
  output logic        write_enable_n,
  output logic        bank_select_lo,
  output logic        bank_select_hi,
  output logic [11:0] address,
  output logic [31:0] wdata,
  output logic [3:0]  byte_mask,
  output logic        self_refresh_exit
);
  // self refresh is never entered, so no exit pulse
  assign self_refresh_exit = 1'b0;
  // inhibit from time zero; burst terminate never issued
  initial begin
    clock_enable = 1'b1;
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'hF;
    {bank_select_hi, bank_select_lo, address, wdata, byte_mask} = '0;
  end
  // one command per cycle, launched just after the edge
  task automatic step(input logic [3:0] code, input logic [1:0] b, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] m);
    @(posedge clk);
    #1;
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = code;
    {bank_select_hi, bank_select_lo} = b;
    address = a;
    wdata = d;
    byte_mask = m;
  endtask
  // unused lines toggle so stale values cannot pass; no write ever cuts a read
  task automatic nop();
    logic [31:0] r;
    r = $urandom;
    step(4'h7, r[1:0], r[11:0], r, 4'h0);
  endtask
  // power-up wait, precharge all, two refreshes, then mode load
  task automatic init();
    repeat (POWER_UP_CYC) step(4'hF, 2'h0, 12'h000, 32'h0, 4'h0);
    nop();
    step(4'h2, 2'h0, 12'h400, 32'h0, 4'h0);
    repeat (2) begin
      repeat (GAP_CYC) nop();
      step(4'h1, 2'h0, 12'h000, 32'h0, 4'h0);
    end
    repeat (GAP_CYC) nop();
    step(4'h0, 2'h0, 12'h023, 32'h0, 4'h0);
    repeat (GAP_CYC) nop();
  endtask
endmodule // sdmb_ctl_model

// ===== verification/sdmb_core_test.sv
// self-checking bench of the sdram command core
`timescale 1ns/1ps
module sdmb_core_test;
  import sdmb_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              rdata_ready = 1'b1;
  logic              cke, cs_n, ras_n, cas_n, we_n, bs_lo, bs_hi, sr_exit, rdata_valid;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        byte_mask, bank_idle;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] mem[BANKS][8];
  int                err_total = 0;
  int                total_checks = 0;
  always #25 clk = ~clk;
  sdmb_core #(.SR_EXIT(4)) u_dut (.clk(clk), .rst_n(rst_n), .clock_enable(cke),
    .chip_select_n(cs_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .write_enable_n(we_n), .bank_select_lo(bs_lo), .bank_select_hi(bs_hi),
    .address(address), .wdata(wdata), .byte_mask(byte_mask), .self_refresh_exit(sr_exit),
    .rdata(rdata), .rdata_valid(rdata_valid), .rdata_ready(rdata_ready),
    .bank_idle(bank_idle));
  sdmb_ctl_model u_ctl (.clk(clk), .clock_enable(cke), .chip_select_n(cs_n),
    .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_enable_n(we_n),
    .bank_select_lo(bs_lo), .bank_select_hi(bs_hi), .address(address), .wdata(wdata),
    .byte_mask(byte_mask), .self_refresh_exit(sr_exit));
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // random stalls on the read side to back up the fifo
  always @(posedge clk) begin
    #1;
    rdata_ready = ($urandom % 4) != 0;
  end
  // scoreboard takes the oldest note whenever a word leaves
  always @(posedge clk) begin
    if (rst_n && rdata_valid === 1'b1 && rdata_ready === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(rdata, exp_q.pop_front());
    end
  end
  task automatic act(input logic [1:0] b);
    u_ctl.step(4'h3, b, {1'b0, 11'($urandom)}, 32'h0, 4'h0);
    u_ctl.nop();
  endtask
  // burst wraps inside its block of eight columns
  task automatic wr(input logic [1:0] b, input logic [2:0] col, input logic ap, input int n,
                    input logic [3:0] m);
    logic [DATA_W-1:0] d;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      if (m == 4'h0) mem[b][col + 3'(i)] = d;
      if (i == 0) u_ctl.step(4'h4, b, {1'b0, ap, 7'h0, col}, d, m);
      else u_ctl.step(4'h7, b, 12'(d), d, m);
    end
  endtask
  task automatic rd(input logic [1:0] b, input logic [2:0] col, input logic ap, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(mem[b][col + 3'(i)]);
    u_ctl.step(4'h5, b, {1'b0, ap, 7'h0, col}, 32'h0, 4'h0);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    void'($urandom(98268));
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    u_ctl.init();
    check({28'h0, bank_idle}, 32'hF);
    for (int b = 0; b < 4; b++) act(2'(b));
    check({28'h0, bank_idle}, 32'h0);
    for (int b = 0; b < 4; b++) wr(2'(b), 3'($urandom), 1'b0, 8, 4'h0);
    rd(2'h0, 3'($urandom), 1'b0, 3);
    repeat (2) u_ctl.nop();
    rd(2'h1, 3'($urandom), 1'b0, 8);
    repeat (7) u_ctl.nop();
    wr(2'h0, 3'h2, 1'b0, 2, 4'h0);
    wr(2'h1, 3'h5, 1'b0, 3, 4'h0);
    rd(2'h0, 3'h0, 1'b0, 8);
    u_ctl.nop();
    u_ctl.step(4'h2, 2'h1, 12'h000, 32'h0, 4'h0);
    repeat (6) u_ctl.nop();
    check({28'h0, bank_idle}, 32'h2);
    act(2'h1);
    rd(2'h1, 3'h0, 1'b0, 8);
    repeat (8) u_ctl.nop();
    u_ctl.step(4'hD, 2'h0, 12'h000, 32'h0, 4'h0);
    u_ctl.clock_enable = 1'b0;
    u_ctl.step(4'h5, 2'h0, 12'h000, 32'h0, 4'h0);
    u_ctl.clock_enable = 1'b1;
    repeat (8) u_ctl.nop();
    rd(2'h0, 3'h1, 1'b1, 2);
    u_ctl.nop();
    rd(2'h1, 3'h0, 1'b0, 8);
    repeat (7) u_ctl.nop();
    check({31'h0, bank_idle[0]}, 32'h1);
    u_ctl.clock_enable = 1'b0;
    u_ctl.step(4'h3, 2'h0, 12'h000, 32'h0, 4'h0);
    u_ctl.clock_enable = 1'b1;
    u_ctl.nop();
    check({31'h0, bank_idle[0]}, 32'h1);
    act(2'h0);
    wr(2'h0, 3'h4, 1'b1, 2, 4'h0);
    wr(2'h1, 3'h0, 1'b0, 8, 4'h0);
    check({31'h0, bank_idle[0]}, 32'h1);
    act(2'h0);
    wr(2'h0, 3'h0, 1'b0, 8, 4'hF);
    rd(2'h0, 3'h0, 1'b0, 8);
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) u_ctl.nop();
    check(32'(exp_q.size()), 32'h0);
    final_report();
  end
endmodule // sdmb_core_test
